//--- rtl/link_status_pkg.sv
// Package: offsets, field positions, reset values and carriers for the block
package link_status_pkg;

    // Register word offsets on the plain port
    localparam logic [9:0] status_offset = 10'h208;
    localparam logic [9:0] powerdown_offset = 10'h209;
    localparam logic [9:0] irq_status_offset = 10'h210;
    localparam logic [9:0] irq_mask_offset = 10'h211;

    // Status field positions
    localparam int link_up_bit = 6;
    localparam int sync_state_bit = 5;
    localparam int realigned_bit = 4;
    localparam int phase_set_bit = 3;
    localparam int pll_lock_bit = 2;

    // Power-down field positions
    localparam int second_off_bit = 1;
    localparam int first_off_bit = 0;

    // Interrupt event positions
    localparam int irq_realign_bit = 0;
    localparam int irq_phase_set_bit = 1;
    localparam int irq_lock_lost_bit = 2;
    localparam int irq_link_drop_bit = 3;

    // Reset values
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] powerdown_reset = 8'h00;
    localparam logic [3:0] irq_reset = 4'h0;

    // Live conditions from the link logic
    typedef struct packed {
        logic link_up;      // Link established
        logic sync_n;       // Receiver sync request, low = asserted
        logic realign;      // Pulse: SYSREF moved a clock phase
        logic sysref;       // Pulse: SYSREF event seen
        logic pll_locked;   // Serializer PLL lock
    } link_cond_s;

    // Power-down controls to the analog and link logic
    typedef struct packed {
        logic first_off;    // Channel A and its digital channels
        logic second_off;   // Channel B and its digital channels
        logic link_off;     // Whole serial link subsystem
    } power_ctl_s;

endpackage

//--- rtl/w1c_flag.sv
// Sticky flag: hardware set beats a write-one clear in the same cycle
module w1c_flag
    import link_status_pkg::*;
(
    input wire logic clock,   // System clock
    input wire logic rst,     // Async reset, high
    input wire logic set,     // Event pulse
    input wire logic clear,   // Write-one clear
    output logic flag         // Sticky state
);

    // Set wins so no event is lost
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            flag <= 1'b0;
        else if (set)
            flag <= 1'b1;
        else if (clear)
            flag <= 1'b0;
    end

    // Set always lands next cycle
    set_wins_a: assert property (@(posedge clock) disable iff (rst)
        set |=> flag)
        else $error("sticky flag lost a set");

endmodule

//--- rtl/powerdown_ctl.sv
// Channel power-down decoding from the power-down register
module powerdown_ctl
    import link_status_pkg::*;
(
    input wire logic [7:0] pd_reg,     // Power-down register value
    input wire logic mode_both_off,    // General mode both channels off
    output power_ctl_s ctl             // Decoded controls
);

    wire first_req = pd_reg[first_off_bit] | mode_both_off;  // see RQ7
    wire second_req = pd_reg[second_off_bit] | mode_both_off; // see RQ6

    // Link stays up with one channel off; both off kills it
    assign ctl.first_off = first_req;               // see RQ7
    assign ctl.second_off = second_req;             // see RQ6, RQ10
    assign ctl.link_off = first_req & second_req;   // see RQ9

endmodule

//--- rtl/link_status_regs.sv
// Serial link status and channel power-down register bank
//
// Contract
// RQ1: Bit 6 shows link up, live
// RQ2: Bit 5 reads zero while sync asserted
// RQ3: Bit 4 sticky realign, write one clears
// RQ4: Bit 3 sticky first phase set, W1C
// RQ5: Bit 2 shows serializer PLL lock, live
// RQ6: Power-down bit 1 shuts channel B
// RQ7: Power-down bit 0 shuts channel A
// RQ8: Software disables link output before power changes
// RQ9: Both channels off shuts whole link
// RQ10: Link A runs with B channel off
// RQ11: Software uses mode register for both off
// RQ12: Software sets spare-core field for calibration
// RQ13: Writes to live status bits ignored
module link_status_regs
    import link_status_pkg::*;
(
    input wire logic clock,              // 200 MHz system clock
    input wire logic rst,                // Async reset, high
    input wire logic [9:0] addr,         // Register word offset
    input wire logic [7:0] wdata,        // Write data
    input wire logic wr,                 // Write strobe
    input wire logic rd,                 // Read strobe
    output logic [7:0] rdata,            // Read data, cycle after rd
    input wire link_cond_s cond,         // Live link conditions
    input wire logic link_output_enable, // Link encoder enabled
    input wire logic mode_both_off,      // Mode register both off
    output power_ctl_s power,            // Registered power controls
    output logic irq                     // Level interrupt
);

    // Decoded strobes
    wire wr_status = wr && (addr == status_offset); // see RQ13
    wire wr_pd = wr && (addr == powerdown_offset);
    wire wr_irq = wr && (addr == irq_status_offset);
    wire wr_mask = wr && (addr == irq_mask_offset);

    logic [7:0] pd_reg;          // Channel power-down register
    logic [7:0] pd_next;         // Next power-down value
    logic [3:0] mask_reg;        // Interrupt mask
    logic enc_en_reg;            // Previous encoder enable
    logic phase_armed_reg;       // Waiting for first SYSREF after enable
    logic pll_lock_reg;          // Previous PLL lock
    logic link_up_reg;           // Previous link up
    logic realign_flag;          // Sticky realign
    logic phase_flag;            // Sticky phase set
    logic [3:0] irq_flags;       // Interrupt status
    logic [7:0] rdata_next;      // Read mux output
    power_ctl_s power_next;      // Decoded controls

    // First SYSREF after encoder enable sets the phase flag
    wire enc_rise = link_output_enable && !enc_en_reg;
    // Enable gates the event too, so a SYSREF in the cycle that the
    // encoder drops cannot set the flag from a stale arm
    wire phase_event = cond.sysref && link_output_enable // see RQ4
        && (phase_armed_reg || enc_rise);
    wire lock_lost = pll_lock_reg && !cond.pll_locked;
    wire link_drop = link_up_reg && !cond.link_up;

    // Events feeding the interrupt status
    wire [3:0] irq_events = {link_drop, lock_lost, phase_event, cond.realign};

    // Only reserved bits of power-down are dropped
    assign pd_next = wr_pd ? (wdata & 8'h03) : pd_reg;

    // Sticky status bits cleared by writing one
    w1c_flag realign_u (
        .clock(clock),
        .rst(rst),
        .set(cond.realign),                      // see RQ3
        .clear(wr_status && wdata[realigned_bit]), // see RQ3
        .flag(realign_flag)
    );

    w1c_flag phase_u (
        .clock(clock),
        .rst(rst),
        .set(phase_event),                       // see RQ4
        .clear(wr_status && wdata[phase_set_bit]), // see RQ4
        .flag(phase_flag)
    );

    // Interrupt status flags, one per event
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : irq_gen
            w1c_flag irq_u (
                .clock(clock),
                .rst(rst),
                .set(irq_events[gi]),
                .clear(wr_irq && wdata[gi]),
                .flag(irq_flags[gi])
            );
        end
    endgenerate

    // Power decode from the next register value
    powerdown_ctl pd_u (
        .pd_reg(pd_next),
        .mode_both_off(mode_both_off),
        .ctl(power_next)
    );

    // Read mux; live bits come straight from the conditions
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (1'b1)
            rd && (addr == status_offset):
            begin
                rdata_next[link_up_bit] = cond.link_up;      // see RQ1
                rdata_next[sync_state_bit] = cond.sync_n;    // see RQ2
                rdata_next[realigned_bit] = realign_flag;    // see RQ3
                rdata_next[phase_set_bit] = phase_flag;      // see RQ4
                rdata_next[pll_lock_bit] = cond.pll_locked;  // see RQ5
            end
            rd && (addr == powerdown_offset):
                rdata_next = pd_reg;
            rd && (addr == irq_status_offset):
                rdata_next = {4'h0, irq_flags};
            rd && (addr == irq_mask_offset):
                rdata_next = {4'h0, mask_reg};
            default:
                rdata_next = 8'h00;
        endcase
    end

    // Power-down register; written regardless of link enable
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pd_reg <= powerdown_reset;
        else
            pd_reg <= pd_next;                            // see RQ6, RQ7
    end

    // Registered power controls
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            power <= '0;
        else
            power <= power_next;                          // see RQ9
    end

    // Mask register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            mask_reg <= irq_reset;
        else if (wr_mask)
            mask_reg <= wdata[3:0];
    end

    // Edge history for events
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            enc_en_reg <= 1'b0;
            pll_lock_reg <= 1'b0;
            link_up_reg <= 1'b0;
        end
        else
        begin
            enc_en_reg <= link_output_enable;
            pll_lock_reg <= cond.pll_locked;
            link_up_reg <= cond.link_up;
        end
    end

    // Arm on enable, disarm on first SYSREF or when disabled
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            phase_armed_reg <= 1'b0;
        else if (!link_output_enable || phase_event)
            phase_armed_reg <= 1'b0;                      // see RQ4
        else if (enc_rise)
            phase_armed_reg <= 1'b1;
    end

    // Read data and interrupt, both registered
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            rdata <= rdata_next;
            irq <= |(irq_flags & mask_reg);
        end
    end

    // Status reads mirror live link and lock, writes ignored
    live_bits_a: assert property (@(posedge clock) // see RQ1, RQ5, RQ13
        disable iff (rst)
        rd && addr == status_offset |=>
        rdata[link_up_bit] == $past(cond.link_up)
        && rdata[pll_lock_bit] == $past(cond.pll_locked))
        else $error("status live bits wrong");

    sync_bit_a: assert property (@(posedge clock) // see RQ2
        disable iff (rst)
        rd && addr == status_offset |=>
        rdata[sync_state_bit] == $past(cond.sync_n))
        else $error("sync bit wrong");

    // Reserved status bits always read zero
    status_rsvd_a: assert property (@(posedge clock)
        disable iff (rst)
        rd && addr == status_offset |=>
        rdata[7] == 1'b0 && rdata[1:0] == 2'b00)
        else $error("reserved status bit set");

    // Read data falls back to zero outside a read
    rdata_idle_a: assert property (@(posedge clock)
        disable iff (rst)
        !rd |=> rdata == 8'h00)
        else $error("read data left standing");

    // Realign flag latches and holds until cleared
    realign_sticky_a: assert property (@(posedge clock) // see RQ3
        disable iff (rst)
        cond.realign
        || (realign_flag && !(wr_status && wdata[realigned_bit]))
        |=> realign_flag)
        else $error("realign not latched");

    realign_clear_a: assert property (@(posedge clock) // see RQ3
        disable iff (rst)
        wr_status && wdata[realigned_bit] && !cond.realign
        |=> !realign_flag)
        else $error("realign not cleared");

    // Phase flag: set once per enable, held, cleared by a one
    phase_first_a: assert property (@(posedge clock) // see RQ4
        disable iff (rst)
        phase_event |=> phase_flag && !phase_armed_reg)
        else $error("phase flag not set once");

    phase_hold_a: assert property (@(posedge clock) // see RQ4
        disable iff (rst)
        phase_flag && !(wr_status && wdata[phase_set_bit]) |=> phase_flag)
        else $error("phase flag lost");

    phase_clear_a: assert property (@(posedge clock) // see RQ4
        disable iff (rst)
        wr_status && wdata[phase_set_bit] && !phase_event
        |=> !phase_flag)
        else $error("phase flag not cleared");

    // A disabled encoder never sets the phase flag
    phase_idle_a: assert property (@(posedge clock) // see RQ4
        disable iff (rst)
        !link_output_enable && !phase_flag |=> !phase_flag)
        else $error("phase flag set while disabled");

    // Power controls follow the register and the mode input
    chan_b_off_a: assert property (@(posedge clock) // see RQ6
        disable iff (rst)
        pd_reg[second_off_bit] |-> power.second_off)
        else $error("channel B not off");

    chan_a_off_a: assert property (@(posedge clock) // see RQ7
        disable iff (rst)
        pd_reg[first_off_bit] |-> power.first_off)
        else $error("channel A not off");

    link_off_a: assert property (@(posedge clock) // see RQ9, RQ10
        disable iff (rst)
        power.link_off == (power.first_off && power.second_off))
        else $error("link power wrong");

    mode_off_a: assert property (@(posedge clock) // see RQ9
        disable iff (rst)
        mode_both_off |=> power.link_off)
        else $error("mode did not power down link");

    pd_write_a: assert property (@(posedge clock) // see RQ6, RQ7
        disable iff (rst)
        wr_pd |=> pd_reg == ($past(wdata) & 8'h03))
        else $error("power-down write lost");

    // Every event lands in its interrupt flag
    realign_irq_a: assert property (@(posedge clock)
        disable iff (rst)
        cond.realign |=> irq_flags[irq_realign_bit])
        else $error("realign interrupt lost");

    phase_irq_a: assert property (@(posedge clock)
        disable iff (rst)
        phase_event |=> irq_flags[irq_phase_set_bit])
        else $error("phase interrupt lost");

    lock_lost_a: assert property (@(posedge clock)
        disable iff (rst)
        lock_lost |=> irq_flags[irq_lock_lost_bit])
        else $error("lock loss interrupt lost");

    link_drop_a: assert property (@(posedge clock)
        disable iff (rst)
        link_drop |=> irq_flags[irq_link_drop_bit])
        else $error("link drop interrupt lost");

    // Interrupt level follows the unmasked flags
    irq_level_a: assert property (@(posedge clock)
        disable iff (rst)
        (|(irq_flags & mask_reg)) |=> irq)
        else $error("interrupt not raised");

    irq_low_a: assert property (@(posedge clock)
        disable iff (rst)
        !(|(irq_flags & mask_reg)) |=> !irq)
        else $error("interrupt raised while masked");

endmodule

//--- tb/link_far_end.sv
// Far-end model: receiver sync, link state, PLL lock and SYSREF events
module link_far_end
    import link_status_pkg::*;
(
    input wire logic clock,       // System clock
    input wire power_ctl_s power, // Power controls from the block
    output link_cond_s cond       // Conditions seen by the block
);
    timeunit 1ns;
    timeprecision 100ps;

    logic up_reg = 1'b0;      // Receiver reports link up
    logic sync_reg = 1'b1;    // Sync request, low = asserted
    logic lock_reg = 1'b0;    // Serializer PLL lock
    logic realign_reg = 1'b0; // Realign pulse
    logic sysref_reg = 1'b0;  // SYSREF pulse
    logic off;                // Whole link powered down

    // A dead link cannot stay up or locked, and the receiver's sync request reads released (high)
    assign off = power.link_off;
    assign cond = {up_reg & ~off, sync_reg | off, realign_reg, sysref_reg,
        lock_reg & ~off};

    // Levels change just after an edge, as the far side would
    task automatic levels(input logic up, input logic sync_n, input logic lk);
        @(posedge clock);
        up_reg <= up;
        sync_reg <= sync_n;
        lock_reg <= lk;
    endtask

    // One-cycle event: SYSREF when high, realign when low
    task automatic pulse(input logic sysref);
        @(posedge clock);
        sysref_reg <= sysref;
        realign_reg <= ~sysref;
        @(posedge clock);
        sysref_reg <= 1'b0;
        realign_reg <= 1'b0;
    endtask
endmodule

//--- tb/test_serial_link_status_and_channel_powerdown.sv
// Testbench for the link status and channel power-down register bank
module test_serial_link_status_and_channel_powerdown
    import link_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;        // 200 MHz clock
    logic rst = 1'b1;          // Reset, high
    logic [9:0] addr = 10'h0;  // Register offset
    logic [7:0] wdata = 8'h0;  // Write data
    logic wr = 1'b0;           // Write strobe
    logic rd = 1'b0;           // Read strobe
    logic en = 1'b0;           // Link output enable
    logic both_off = 1'b0;     // Mode register both off
    logic [7:0] rdata;         // Read data
    link_cond_s cond;          // From far end
    power_ctl_s power;         // To far end
    logic irq;                 // Interrupt
    int errors = 0;            // Mismatches
    int check_count = 0;       // Comparisons

    always #2.5 clock = ~clock;

    link_status_regs dut (.clock(clock), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cond(cond),
        .link_output_enable(en), .mode_both_off(both_off),
        .power(power), .irq(irq));
    link_far_end far (.clock(clock), .power(power), .cond(cond));

    // Compare one value, unknowns never match
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Let a few edges pass so live inputs land
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One-cycle write
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // One-cycle read; data stands only in the next cycle
    task automatic rd_reg(input logic [9:0] a, input logic [7:0] exp,
        input string what);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // Print counts and verdict, then stop
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Reset values and an unmapped place
    task automatic t_reset();
        rd_reg(status_offset, 8'h20, "status");
        rd_reg(powerdown_offset, 8'h00, "powerdown");
        rd_reg(10'h20a, 8'h00, "unmapped");
        rd_reg(irq_mask_offset, 8'h00, "mask");
        $display("reset test done");
    endtask

    // Live bits follow the far end and ignore writes
    task automatic t_live();
        far.levels(1'b1, 1'b0, 1'b1);
        idle(3);
        rd_reg(status_offset, 8'h44, "status live");
        wr_reg(status_offset, 8'hff);
        rd_reg(status_offset, 8'h44, "status after write");
        far.levels(1'b1, 1'b1, 1'b0);
        idle(3);
        rd_reg(status_offset, 8'h60, "status sync pll");
        $display("live test done");
    endtask

    // Sticky realign and first-SYSREF phase flags
    task automatic t_sticky();
        far.pulse(1'b0);
        idle(3);
        rd_reg(status_offset, 8'h70, "realign");
        far.pulse(1'b1);
        idle(3);
        rd_reg(status_offset, 8'h70, "sysref disabled");
        @(posedge clock);
        en <= 1'b1;
        far.pulse(1'b1);
        idle(3);
        rd_reg(status_offset, 8'h78, "phase set");
        wr_reg(status_offset, 8'h10);
        rd_reg(status_offset, 8'h68, "realign clear");
        wr_reg(status_offset, 8'h08);
        far.pulse(1'b1);
        idle(3);
        rd_reg(status_offset, 8'h60, "second sysref");
        @(posedge clock);
        en <= 1'b0;
        idle(2);
        $display("sticky test done");
    endtask

    // Every power-down code with the link output held off
    task automatic t_power();
        // Spare-core calibration field is left to software
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(powerdown_offset, 8'(i));
            idle(2);
            chk("power", {5'h0, i[0], i[1], i == 3}, power);
            rd_reg(powerdown_offset, 8'(i), "powerdown");
            // Far end drops link and lock only when both are off
            rd_reg(status_offset, (i == 3) ? 8'h20 : 8'h60,
                "status power");
        end
        wr_reg(powerdown_offset, 8'h00);
        both_off <= 1'b1;
        idle(2);
        chk("mode power", 8'h07, power);
        both_off <= 1'b0;
        idle(2);
        $display("power test done");
    endtask

    // Interrupt raised, masked and cleared
    task automatic t_irq();
        rd_reg(irq_status_offset, 8'h0f, "irq events");
        wr_reg(irq_status_offset, 8'h0f);
        wr_reg(irq_mask_offset, 8'h00);
        far.pulse(1'b0);
        idle(3);
        chk("irq masked", 8'h00, irq);
        rd_reg(irq_status_offset, 8'h01, "irq status");
        wr_reg(irq_mask_offset, 8'h01);
        idle(3);
        chk("irq", 8'h01, irq);
        wr_reg(irq_status_offset, 8'h01);
        idle(3);
        chk("irq cleared", 8'h00, irq);
        $display("irq test done");
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_live();
        t_sticky();
        t_power();
        t_irq();
        wrap_up();
    end

    // Watchdog, far beyond the roughly 150 cycles the tests need
    initial
    begin
        #50000;
        errors++;
        wrap_up();
    end
endmodule
